// >>> sdec_pkg.sv
// sdec_pkg: register map, field layout and reset values of the switch drop event capture block.
// assumes a 32-bit classic wishbone slave that uses word addresses (register numbers).
package sdec_pkg;

   // register numbers; the byte address is four times the number
   localparam logic [15:0] ADDR_P2_UNLEARNED = 16'h185a;
   localparam logic [15:0] ADDR_IRQ_MASK     = 16'h1880;
   localparam logic [15:0] ADDR_DROP_PENDING = 16'h1881;
   localparam logic [15:0] ADDR_IRQ_STATUS   = 16'h1890;
   localparam logic [15:0] ADDR_IRQ_ENABLE   = 16'h1891;

   // pending register layout
   localparam int PEND_BIT    = 0;
   localparam int A_VALID_BIT = 1;
   localparam int A_PORT_LSB  = 2;
   localparam int A_RSN_LSB   = 4;
   localparam int B_VALID_BIT = 8;
   localparam int B_PORT_LSB  = 9;
   localparam int B_RSN_LSB   = 11;

   // reset values, count limit and unmapped read value
   localparam logic [31:0] RST_COUNT   = 32'h0000_0000;
   localparam logic [31:0] COUNT_MAX   = 32'hffff_ffff;
   localparam logic        RST_MASK    = 1'b1;
   localparam logic [31:0] RST_PENDING = 32'h0000_0000;
   localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;

   // source-port codes
   localparam logic [1:0] PORT_0   = 2'h0;
   localparam logic [1:0] PORT_1   = 2'h1;
   localparam logic [1:0] PORT_2   = 2'h2;
   localparam logic [1:0] PORT_RSV = 2'h3;

   // drop reason codes
   typedef enum logic [3:0] {
      SDEC_RSN_TAGGED_ONLY    = 4'h0,
      SDEC_RSN_UNK_NONMEMBER  = 4'h1,
      SDEC_RSN_KNOWN_SRC_FWD  = 4'h2,
      SDEC_RSN_DST_NOT_FWD    = 4'h3,
      SDEC_RSN_DST_NONMEMBER  = 4'h4,
      SDEC_RSN_KNOWN_NONMEMB  = 4'h5,
      SDEC_RSN_UNK_UNICAST    = 4'h6,
      SDEC_RSN_UNK_MULTICAST  = 4'h7,
      SDEC_RSN_BCAST_THROTTLE = 4'h8,
      SDEC_RSN_UNK_SRC_FWD    = 4'h9,
      SDEC_RSN_SAME_PORT      = 4'ha,
      SDEC_RSN_FILTERED       = 4'hb,
      SDEC_RSN_VID_ALL_ONES   = 4'he
   } sdec_reason_e;

   // interrupt status / enable bits of the wrapper registers
   localparam int IRQ_DROP_BIT  = 0;
   localparam int IRQ_LEARN_BIT = 1;
   localparam int IRQ_SAT_BIT   = 2;
   localparam int IRQ_W         = 3;

endpackage

// >>> sdec_top.sv
// sdec_top: drop event capture, switch interrupt mask and port 2 unlearned count.
// assumes a classic wishbone master, event inputs synchronous to clk_i, one-cycle pulses.
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/1ps

module sdec_top #(
   parameter int ADDR_W = 16
) (
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic [ADDR_W-1:0] adr_i,
   input  wire logic [31:0]       dat_i,
   input  wire logic [3:0]        sel_i,
   input  wire logic              we_i,
   input  wire logic              cyc_i,
   input  wire logic              stb_i,
   output logic      [31:0]       dat_o,
   output logic                   ack_o,
   input  wire logic              drop_valid_i,
   input  wire logic [3:0]        drop_reason_i,
   input  wire logic [1:0]        drop_port_i,
   input  wire logic              p2_learn_fail_i,
   output logic                   switch_irq_o,
   output logic                   irq_o
);

   // refuse address widths that cannot reach the map
   if (ADDR_W < 13)
   begin : g_chk
      $error("sdec_top: ADDR_W must be at least 13");
   end

   // status width, declared ahead of the state struct that uses it
   localparam int IRQ_W_L = sdec_pkg::IRQ_W;

   typedef struct packed {
      logic [31:0]        count;
      logic               mask;
      logic               pend;
      logic               a_valid;
      logic [1:0]         a_port;
      logic [3:0]         a_rsn;
      logic               b_valid;
      logic [1:0]         b_port;
      logic [3:0]         b_rsn;
      logic [IRQ_W_L-1:0] irq_stat;
      logic [IRQ_W_L-1:0] irq_en;
      logic [31:0]        dat;
      logic               ack;
      logic               sw_irq;
      logic               irq;
   } sdec_state_s;

   sdec_state_s s_q;
   sdec_state_s s_d;

   // reserved reason codes are mapped to SDEC_RSN_VID_ALL_ONES so they are never reported
   function automatic logic [3:0] sdec_legal_reason(input logic [3:0] r);
      logic [3:0] v;
      v = r;
      if (r == 4'hc || r == 4'hd || r == 4'hf)
         v = sdec_pkg::SDEC_RSN_VID_ALL_ONES;
      return v;
   endfunction

   function automatic logic sdec_hit(input logic [ADDR_W-1:0] a, input logic [15:0] r);
      return a == ADDR_W'(r);
   endfunction

   logic [31:0] pend_word;
   logic        rd_stb;
   logic        wr_stb;
   logic        cnt_sat;

   // assembled pending word, reserved bits zero
   // slot A and slot B layout
   always_comb
   begin
      pend_word = sdec_pkg::RST_PENDING;
      pend_word[sdec_pkg::PEND_BIT] = s_q.pend;
      pend_word[sdec_pkg::A_VALID_BIT] = s_q.a_valid;
      pend_word[sdec_pkg::A_PORT_LSB +: 2] = s_q.a_port;
      pend_word[sdec_pkg::A_RSN_LSB +: 4] = s_q.a_rsn;
      pend_word[sdec_pkg::B_VALID_BIT] = s_q.b_valid;
      pend_word[sdec_pkg::B_PORT_LSB +: 2] = s_q.b_port;
      pend_word[sdec_pkg::B_RSN_LSB +: 4] = s_q.b_rsn;
   end

   // a request is served once: ack lasts one cycle, then drops
   assign rd_stb  = cyc_i && stb_i && !we_i && !s_q.ack;
   assign wr_stb  = cyc_i && stb_i && we_i && !s_q.ack;
   assign cnt_sat = s_q.count == sdec_pkg::COUNT_MAX;

   // next-state logic: bus, capture, counter, interrupts
   always_comb
   begin
      logic drop_ok;
      logic [IRQ_W_L-1:0] ev;
      drop_ok = drop_valid_i && (drop_port_i != sdec_pkg::PORT_RSV);
      ev = '0;
      s_d = s_q;
      s_d.ack = cyc_i && stb_i && !s_q.ack;
      s_d.dat = sdec_pkg::UNMAPPED_RD;

      // read path; clear-on-read effects come first so events override them
      if (rd_stb)
      begin
         if (sdec_hit(adr_i, sdec_pkg::ADDR_P2_UNLEARNED))
         begin
            s_d.dat = s_q.count;
            s_d.count = sdec_pkg::RST_COUNT;
         end
         else if (sdec_hit(adr_i, sdec_pkg::ADDR_IRQ_MASK))
         begin
            s_d.dat = {31'h0000_0000, s_q.mask};
         end
         else if (sdec_hit(adr_i, sdec_pkg::ADDR_DROP_PENDING))
         begin
            s_d.dat = pend_word;
            s_d.pend = 1'b0;
            s_d.a_valid = 1'b0;
            s_d.a_port = sdec_pkg::PORT_0;
            s_d.a_rsn = 4'h0;
            s_d.b_valid = 1'b0;
            s_d.b_port = sdec_pkg::PORT_0;
            s_d.b_rsn = 4'h0;
         end
         else if (sdec_hit(adr_i, sdec_pkg::ADDR_IRQ_STATUS))
         begin
            s_d.dat = {29'h0000_0000, s_q.irq_stat};
            s_d.irq_stat = '0;
         end
         else if (sdec_hit(adr_i, sdec_pkg::ADDR_IRQ_ENABLE))
         begin
            s_d.dat = {29'h0000_0000, s_q.irq_en};
         end
      end

      // write path: only low byte lane carries the writable bits
      if (wr_stb && sel_i[0])
      begin
         if (sdec_hit(adr_i, sdec_pkg::ADDR_IRQ_MASK))
         begin
            s_d.mask = dat_i[0];
         end
         else if (sdec_hit(adr_i, sdec_pkg::ADDR_IRQ_ENABLE))
         begin
            s_d.irq_en = dat_i[IRQ_W_L-1:0];
         end
      end

      if (p2_learn_fail_i)
      begin
         ev[sdec_pkg::IRQ_LEARN_BIT] = 1'b1;
         if (!cnt_sat || s_d.count != s_q.count)
            s_d.count = s_d.count + 32'h0000_0001;
         if (s_d.count == sdec_pkg::COUNT_MAX)
            ev[sdec_pkg::IRQ_SAT_BIT] = 1'b1;
      end

      // capture beats a same-cycle read clear, so no event is lost
      // two slots
      if (drop_ok)
      begin
         s_d.pend = 1'b1;
         ev[sdec_pkg::IRQ_DROP_BIT] = 1'b1;
         if (!s_d.a_valid)
         begin
            s_d.a_valid = 1'b1;
            s_d.a_port = drop_port_i;
            s_d.a_rsn = sdec_legal_reason(drop_reason_i);
         end
         else if (!s_d.b_valid)
         begin
            s_d.b_valid = 1'b1;
            s_d.b_port = drop_port_i;
            s_d.b_rsn = sdec_legal_reason(drop_reason_i);
         end
      end

      // sticky status, set wins over read clear
      s_d.irq_stat = s_d.irq_stat | ev;

      // switch irq equals pending and not mask, irq is any enabled status bit
      s_d.sw_irq = s_d.pend && !s_d.mask;
      s_d.irq = |(s_d.irq_stat & s_d.irq_en);
   end

   // single state register
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s_q <= '0;
         s_q.count <= sdec_pkg::RST_COUNT;
         s_q.mask <= sdec_pkg::RST_MASK;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign dat_o = s_q.dat;
   assign ack_o = s_q.ack;
   assign switch_irq_o = s_q.sw_irq;
   assign irq_o = s_q.irq;

   sequence s_drop_in;
      drop_valid_i && drop_port_i != sdec_pkg::PORT_RSV;
   endsequence

   // a pending read accepted at this edge
   sequence s_pend_read;
      rd_stb && sdec_hit(adr_i, sdec_pkg::ADDR_DROP_PENDING);
   endsequence

   // a mask write accepted at this edge
   sequence s_mask_write;
      wr_stb && sel_i[0] && sdec_hit(adr_i, sdec_pkg::ADDR_IRQ_MASK);
   endsequence

   a_irq_follows_mask: assert property (@(posedge clk_i) disable iff (rst_i)
      switch_irq_o == (s_q.pend && !s_q.mask))
      else $error("switch irq does not match pending and mask");

   a_mask_blocks_irq: assert property (@(posedge clk_i) disable iff (rst_i)
      s_q.mask |-> !switch_irq_o)
      else $error("switch irq raised while masked");

   a_unmask_irq: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_stb && sel_i[0] && sdec_hit(adr_i, sdec_pkg::ADDR_IRQ_MASK) && !dat_i[0]
       && s_q.pend) |=> switch_irq_o)
      else $error("unmask did not release pending irq");

   a_drop_sets_pend: assert property (@(posedge clk_i) disable iff (rst_i)
      s_drop_in |=> s_q.pend)
      else $error("drop event did not set pending");

   a_slot_a_first: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_drop_in and !s_q.a_valid) |=> (s_q.a_valid && s_q.a_port == $past(drop_port_i)))
      else $error("drop event not captured in slot a");

   a_slot_b_second: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_drop_in and s_q.a_valid and !s_q.b_valid and !rd_stb) |=> s_q.b_valid)
      else $error("second drop event not captured in slot b");

   a_cnt_saturates: assert property (@(posedge clk_i) disable iff (rst_i)
      (cnt_sat && !rd_stb) |=> cnt_sat)
      else $error("unlearned count wrapped");

   a_cnt_counts: assert property (@(posedge clk_i) disable iff (rst_i)
      (p2_learn_fail_i && !cnt_sat && !rd_stb) |=> s_q.count == $past(s_q.count) + 32'h0000_0001)
      else $error("unlearned count did not increment");

   a_cnt_read_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      (rd_stb && sdec_hit(adr_i, sdec_pkg::ADDR_P2_UNLEARNED) && !p2_learn_fail_i)
      |=> (s_q.count == 32'h0000_0000 && dat_o == $past(s_q.count)))
      else $error("count read did not return and clear");

   a_no_rsv_reason: assert property (@(posedge clk_i) disable iff (rst_i)
      s_q.a_rsn != 4'hc && s_q.a_rsn != 4'hd && s_q.a_rsn != 4'hf)
      else $error("reserved reason code reported");

   // bus handshake: one ack per request, never without one
   // the master may hold stb after ack, so ack must still drop
   a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
      ack_o |=> !ack_o)
      else $error("ack lasted more than one cycle");

   // a fresh request is answered at the next edge
   a_ack_answers: assert property (@(posedge clk_i) disable iff (rst_i)
      (cyc_i && stb_i && !ack_o) |=> ack_o)
      else $error("request not acknowledged");

   // no ack without a request
   a_ack_no_req: assert property (@(posedge clk_i) disable iff (rst_i)
      !(cyc_i && stb_i) |=> !ack_o)
      else $error("ack without a request");

   // slot b never holds a reserved reason
   a_no_rsv_reason_b: assert property (@(posedge clk_i) disable iff (rst_i)
      s_q.b_rsn != 4'hc && s_q.b_rsn != 4'hd && s_q.b_rsn != 4'hf)
      else $error("reserved reason code reported in slot b");

   // a valid slot never shows the reserved port code
   a_port_a_legal: assert property (@(posedge clk_i) disable iff (rst_i)
      s_q.a_valid |-> s_q.a_port != sdec_pkg::PORT_RSV)
      else $error("reserved port code in slot a");

   a_port_b_legal: assert property (@(posedge clk_i) disable iff (rst_i)
      s_q.b_valid |-> s_q.b_port != sdec_pkg::PORT_RSV)
      else $error("reserved port code in slot b");

   // a read with no event beside it clears everything
   a_pend_read_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_pend_read and !drop_valid_i) |=> (!s_q.pend && !s_q.a_valid && !s_q.b_valid))
      else $error("pending read did not clear the status");

   // the read returns the word as it stood before the clear
   a_pend_read_data: assert property (@(posedge clk_i) disable iff (rst_i)
      s_pend_read |=> dat_o == $past(pend_word))
      else $error("pending read returned wrong data");

   a_pend_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_q.pend && !rd_stb) |=> s_q.pend)
      else $error("pending cleared without a read");

   // a third event leaves both captured slots alone
   a_third_drop_keeps: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_drop_in and s_q.a_valid && s_q.b_valid && !rd_stb)
      |=> (s_q.a_rsn == $past(s_q.a_rsn) && s_q.b_rsn == $past(s_q.b_rsn)))
      else $error("full slots overwritten by a later drop");

   // the mask bit takes the written value
   a_mask_write: assert property (@(posedge clk_i) disable iff (rst_i)
      s_mask_write |=> s_q.mask == $past(dat_i[0]))
      else $error("mask write not applied");

   // status keeps updating while masked, irq stays low
   a_pend_when_masked: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_drop_in and s_q.mask) |=> (s_q.pend && !switch_irq_o))
      else $error("masked drop misbehaved");

   // an enabled drop status raises the wrapper interrupt
   a_irq_o_drop: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_drop_in and s_q.irq_en[sdec_pkg::IRQ_DROP_BIT]) |=> irq_o)
      else $error("enabled drop status did not raise irq");

   // a legal reason is stored as given
   a_reason_a_kept: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_drop_in and !s_q.a_valid && drop_reason_i != 4'hc && drop_reason_i != 4'hd
       && drop_reason_i != 4'hf) |=> s_q.a_rsn == $past(drop_reason_i))
      else $error("slot a reason not stored as given");

   // the count moves only on a learn failure or a read
   a_cnt_steady: assert property (@(posedge clk_i) disable iff (rst_i)
      (!rd_stb && !p2_learn_fail_i) |=> $stable(s_q.count))
      else $error("unlearned count changed without cause");

endmodule

// >>> testbench.sv
// testbench: self-checking bench for sdec_top with an integer model of the registers.
// assumes sdec_pkg and sdec_top are compiled first; assertions live inside the design.
`timescale 1ns/1ps

module testbench;
   logic        clk_i;
   logic        rst_i;
   logic [15:0] adr_i;
   logic [31:0] dat_i;
   logic [3:0]  sel_i;
   logic        we_i;
   logic        cyc_i;
   logic        stb_i;
   logic [31:0] dat_o;
   logic        ack_o;
   logic        drop_valid_i;
   logic [3:0]  drop_reason_i;
   logic [1:0]  drop_port_i;
   logic        p2_learn_fail_i;
   logic        switch_irq_o;
   logic        irq_o;
   int          errors;
   int          samples_checked;
   int          cycles;
   int          m_cnt;
   logic        m_mask;
   logic [31:0] m_pend;
   logic [31:0] rd;

   sdec_top dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i),
      .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
      .drop_valid_i(drop_valid_i), .drop_reason_i(drop_reason_i), .drop_port_i(drop_port_i),
      .p2_learn_fail_i(p2_learn_fail_i), .switch_irq_o(switch_irq_o), .irq_o(irq_o));

   // 100 mhz clock
   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   task summarize;
      if (errors == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // a hang is cut short well above the fewer than 200 cycles the run needs
   always @(posedge clk_i)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         errors++;
         summarize;
      end
   end

   task check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one classic cycle; waits for ack without assuming its latency
   task wb(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= d;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack_o !== 1'b1 && n < 50);
      q = dat_o;
      if (n >= 50)
         errors++;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask

   task rd_chk(input logic [15:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0000_0000, rd);
      check(rd, exp);
   endtask

   // irq outputs are registered, so look two cycles on, between edges
   task irq_chk(input logic sw, input logic wr);
      repeat (2) @(negedge clk_i);
      check({30'h0, irq_o, switch_irq_o}, {30'h0, wr, sw});
   endtask

   // model: reserved reasons read back as the all-ones vlan code, port 3 is ignored
   task drop(input logic [3:0] r, input logic [1:0] p);
      @(posedge clk_i);
      drop_valid_i  <= 1'b1;
      drop_reason_i <= r;
      drop_port_i   <= p;
      @(posedge clk_i);
      drop_valid_i <= 1'b0;
      if (r inside {4'hc, 4'hd, 4'hf})
         r = 4'he;
      if (p != 2'h3)
      begin
         m_pend[0] = 1'b1;
         if (!m_pend[1])
            m_pend[7:1] = {r, p, 1'b1};
         else if (!m_pend[8])
            m_pend[14:8] = {r, p, 1'b1};
      end
   endtask

   // each high cycle is one unlearned address
   task learn(input int n);
      @(posedge clk_i);
      p2_learn_fail_i <= 1'b1;
      repeat (n) @(posedge clk_i);
      p2_learn_fail_i <= 1'b0;
      m_cnt += n;
   endtask

   initial
   begin
      {adr_i, dat_i, we_i, cyc_i, stb_i, drop_valid_i, drop_reason_i} = '0;
      {drop_port_i, p2_learn_fail_i, errors, samples_checked, cycles, m_cnt} = '0;
      sel_i  = 4'hf;
      rst_i  = 1'b1;
      m_mask = 1'b1;
      m_pend = 32'h0000_0000;
      void'($urandom(95330));
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      // reset values, unmapped read, write to a clear-on-read register ignored
      rd_chk(sdec_pkg::ADDR_P2_UNLEARNED, 32'h0000_0000);
      rd_chk(sdec_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
      rd_chk(16'h1234, sdec_pkg::UNMAPPED_RD);
      wb(1'b1, sdec_pkg::ADDR_DROP_PENDING, 32'hffff_ffff, rd);
      rd_chk(sdec_pkg::ADDR_DROP_PENDING, 32'h0000_0000);
      // every reason code, three events per read (one before the last read) so the third finds both slots full
      for (int i = 0; i < 16; i++)
      begin
         drop(4'(i), 2'($urandom_range(2, 0)));
         if (i % 3 == 2 || i == 15)
         begin
            irq_chk(1'b0, 1'b0);
            rd_chk(sdec_pkg::ADDR_DROP_PENDING, m_pend);
            m_pend = 32'h0000_0000;
         end
      end
      // reserved port code leaves the register untouched
      drop(4'h2, 2'h3);
      rd_chk(sdec_pkg::ADDR_DROP_PENDING, 32'h0000_0000);
      // unmasking lets the pending drop through; the read clears it again
      drop(4'hb, 2'h2);
      wb(1'b1, sdec_pkg::ADDR_IRQ_MASK, 32'h0000_0000, rd);
      irq_chk(1'b1, 1'b0);
      rd_chk(sdec_pkg::ADDR_DROP_PENDING, m_pend);
      m_pend = 32'h0000_0000;
      irq_chk(1'b0, 1'b0);
      wb(1'b1, sdec_pkg::ADDR_IRQ_MASK, 32'hffff_ffff, rd);
      rd_chk(sdec_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
      // unlearned count: read returns the total, then reads zero, writes ignored
      learn($urandom_range(40, 1));
      rd_chk(sdec_pkg::ADDR_P2_UNLEARNED, m_cnt);
      m_cnt = 0;
      wb(1'b1, sdec_pkg::ADDR_P2_UNLEARNED, 32'h0000_00ff, rd);
      rd_chk(sdec_pkg::ADDR_P2_UNLEARNED, 32'h0000_0000);
      // wrapper interrupt: enabled drop event raises it, masked learn event does not
      wb(1'b0, sdec_pkg::ADDR_IRQ_STATUS, 32'h0000_0000, rd);
      wb(1'b1, sdec_pkg::ADDR_IRQ_ENABLE, 32'h0000_0001, rd);
      drop(4'h6, 2'h0);
      irq_chk(1'b0, 1'b1);
      rd_chk(sdec_pkg::ADDR_IRQ_STATUS, 32'h0000_0001);
      irq_chk(1'b0, 1'b0);
      learn(1);
      irq_chk(1'b0, 1'b0);
      rd_chk(sdec_pkg::ADDR_IRQ_STATUS, 32'h0000_0002);
      rd_chk(sdec_pkg::ADDR_DROP_PENDING, m_pend);
      summarize;
   end
endmodule
